// [src/acp_pkg.sv]
// shared constants and a compare function for the amplifier control and diagnostic serial port
package acp_pkg;

  // ****************************************
  // bus framing
  // ****************************************
  localparam logic [6:0] ACP_DEV_ADDR = 7'h48; // target address, arbitrary value
  localparam logic [3:0] ACP_BYTE_BITS = 4'h8;
  localparam logic [6:0] ACP_IDX_FIRST = 7'h01;
  localparam logic [6:0] ACP_IDX_SECOND = 7'h02;
  localparam int ACP_AUTO_BIT = 7;
  localparam logic [1:0] ACP_LAST_CHAN = 2'h3;
  localparam logic [2:0] ACP_WR_LAST = 3'h3;
  localparam logic [2:0] ACP_RD_LAST = 3'h4;
  localparam logic [7:0] ACP_IDLE_BYTE = 8'hff;

  // ****************************************
  // control and diagnostic bit positions
  // ****************************************
  localparam int ACP_DIAG_EN_BIT = 6;
  localparam int ACP_STBY_BIT = 4;
  localparam int ACP_OFFS_BIT = 2;
  localparam int ACP_DIAG_ST_BIT = 6;
  localparam int ACP_STBY_ST_BIT = 7;

  // ****************************************
  // command patterns as mask and value
  // ****************************************
  localparam logic [7:0] ACP_ON_M1 = 8'h5e;
  localparam logic [7:0] ACP_ON_V1 = 8'h00;
  localparam logic [7:0] ACP_ON_M2 = 8'h14;
  localparam logic [7:0] ACP_ON_V2 = 8'h10;
  localparam logic [7:0] ACP_OFF_M1 = 8'h40;
  localparam logic [7:0] ACP_OFF_V1 = 8'h00;
  localparam logic [7:0] ACP_OFF_M2 = 8'h10;
  localparam logic [7:0] ACP_OFF_V2 = 8'h00;
  localparam logic [7:0] ACP_OFS_M1 = 8'h26;
  localparam logic [7:0] ACP_OFS_V1 = 8'h26;

  // ****************************************
  // host timing
  // ****************************************
  localparam int ACP_CLK_NS = 100;
  localparam int ACP_SCL_PERIOD_NS = 10000;
  localparam logic [7:0] ACP_QUARTER_CYC = 8'(ACP_SCL_PERIOD_NS / (4 * ACP_CLK_NS));
  localparam int ACP_GAP_NS = 20000;
  localparam logic [3:0] ACP_GAP_QUARTERS = 4'(ACP_GAP_NS / (ACP_SCL_PERIOD_NS / 4));

  // masked compare of a control byte
  function automatic logic acp_match(input logic [7:0] b, input logic [7:0] m,
                                     input logic [7:0] v);
    acp_match = ((b & m) == v);
  endfunction

endpackage

// [src/acp_i2c_if.sv]
// open-drain two-wire link joining host and device ends
`timescale 1ns/1ns
interface acp_i2c_if;
  logic h_scl_o;
  logic h_scl_oe;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;

  // wired-and resolution, released lines pull high
  assign scl = ~(h_scl_oe & ~h_scl_o);
  assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));

  modport host (output h_scl_o, output h_scl_oe, output h_sda_o, output h_sda_oe,
                input scl, input sda);
  modport dev (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface

// [src/acp_dev.sv]
// device end: serial target holding control bytes and serving diagnostic bytes
`timescale 1ns/1ns
module acp_dev
  import acp_pkg::*;
(
  // clock, reset, enable
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic CE_IN,
  // link
  acp_i2c_if.dev I2C,
  // diagnostic inputs from the analog detectors
  input wire logic [23:0] CHAN_STATUS_IN,
  input wire logic [3:0] OFFSET_FLAG_IN,
  // control outputs
  output logic [7:0] CTRL_FIRST_OUT,
  output logic [7:0] CTRL_SECOND_OUT,
  output logic AMP_ON_OUT,
  output logic DIAG_EN_OUT,
  output logic MUTE_OUT,
  output logic GAIN_26DB_OUT,
  output logic OFFSET_RUN_OUT,
  output logic DIAG_REQ_OUT,
  output logic BUS_HOLD_OUT
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [3:0] {
    D_IDLE, D_ADDR, D_ADDR_ACK, D_SUB, D_SUB_ACK, D_WDATA, D_WACK, D_RDATA, D_RACK,
    D_IGNORE
  } acp_dev_st_t;

  typedef struct packed {
    logic scl_m;
    logic sda_m;
    logic scl_s;
    logic sda_s;
    logic scl_p;
    logic sda_p;
    acp_dev_st_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [6:0] ptr;
    logic auto_inc;
    logic rw;
    logic nack;
    logic wr_seen;
    logic wrote2;
    logic [1:0] rd_idx;
    logic sda_oe;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic gain26;
    logic mute;
    logic offset_run;
    logic diag_req;
  } acp_dev_reg_t;

  acp_dev_reg_t r_ff;
  acp_dev_reg_t nxt_r;
  logic rise;
  logic fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] rd_byte;

  // compose one channel's diagnostic byte
  function automatic logic [7:0] diag_byte(input logic [1:0] idx, input logic [23:0] stat,
                                           input logic [3:0] offs, input logic [7:0] c1,
                                           input logic [7:0] c2, input logic ofs_run);
    logic [7:0] b;
    b = {2'h0, stat[6*idx +: 6]};
    if (ofs_run) begin
      b[ACP_OFFS_BIT] = offs[idx];
    end
    if (idx != ACP_LAST_CHAN) begin
      b[ACP_STBY_ST_BIT] = c2[ACP_STBY_BIT];
      b[ACP_DIAG_ST_BIT] = c1[ACP_DIAG_EN_BIT];
    end
    diag_byte = b;
  endfunction

  // ****************************************
  // line events from the synchronised samples
  // ****************************************
  assign rise = r_ff.scl_s & ~r_ff.scl_p;
  assign fall = ~r_ff.scl_s & r_ff.scl_p;
  assign start_cond = r_ff.scl_s & r_ff.scl_p & r_ff.sda_p & ~r_ff.sda_s;
  assign stop_cond = r_ff.scl_s & r_ff.scl_p & ~r_ff.sda_p & r_ff.sda_s;
  assign rd_byte = diag_byte(r_ff.rd_idx, CHAN_STATUS_IN, OFFSET_FLAG_IN, r_ff.ctrl1,
                             r_ff.ctrl2, r_ff.offset_run);

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    nxt_r = r_ff;
    nxt_r.diag_req = 1'b0;
    nxt_r.scl_m = I2C.scl;
    nxt_r.sda_m = I2C.sda;
    nxt_r.scl_s = r_ff.scl_m;
    nxt_r.sda_s = r_ff.sda_m;
    nxt_r.scl_p = r_ff.scl_s;
    nxt_r.sda_p = r_ff.sda_s;
    if (start_cond) begin
      // a start frees a held line in any state; a stop frees it outside D_RDATA
      nxt_r.st = D_ADDR;
      nxt_r.cnt = '0;
      nxt_r.sda_oe = 1'b0;
      nxt_r.wr_seen = 1'b0;
      nxt_r.wrote2 = 1'b0;
    end else if (stop_cond && (r_ff.st != D_RDATA)) begin
      nxt_r.st = D_IDLE;
      nxt_r.sda_oe = 1'b0;
      if (r_ff.wr_seen) begin
        if (r_ff.wrote2 && r_ff.ctrl1[ACP_DIAG_EN_BIT]) begin
          nxt_r.diag_req = 1'b1;
        end
        if (acp_match(r_ff.ctrl1, ACP_OFF_M1, ACP_OFF_V1) &&
            acp_match(r_ff.ctrl2, ACP_OFF_M2, ACP_OFF_V2)) begin
          nxt_r.mute = 1'b1;
          nxt_r.offset_run = 1'b0;
        end else if (acp_match(r_ff.ctrl1, ACP_ON_M1, ACP_ON_V1) &&
                     acp_match(r_ff.ctrl2, ACP_ON_M2, ACP_ON_V2)) begin
          nxt_r.gain26 = 1'b1;
          nxt_r.mute = 1'b1;
        end
        if (acp_match(r_ff.ctrl1, ACP_OFS_M1, ACP_OFS_V1) &&
            acp_match(r_ff.ctrl2, ACP_ON_M2, ACP_ON_V2)) begin
          nxt_r.offset_run = 1'b1;
        end
      end
    end else begin
      unique case (r_ff.st)
        D_IDLE, D_IGNORE: begin
        end
        D_ADDR, D_SUB, D_WDATA: begin
          if (rise) begin
            nxt_r.sh = {r_ff.sh[6:0], r_ff.sda_s};
            nxt_r.cnt = r_ff.cnt + 4'h1;
          end else if (fall && (r_ff.cnt == ACP_BYTE_BITS)) begin
            nxt_r.cnt = '0;
            nxt_r.sda_oe = 1'b1;
            if (r_ff.st == D_ADDR) begin
              if (r_ff.sh[7:1] != ACP_DEV_ADDR) begin
                nxt_r.sda_oe = 1'b0;
                nxt_r.st = D_IGNORE;
              end else begin
                nxt_r.rw = r_ff.sh[0];
                nxt_r.rd_idx = '0;
                nxt_r.st = D_ADDR_ACK;
              end
            end else if (r_ff.st == D_SUB) begin
              // msb 0 direct; msb 1 increments
              nxt_r.auto_inc = r_ff.sh[ACP_AUTO_BIT];
              nxt_r.ptr = r_ff.sh[6:0];
              nxt_r.st = D_SUB_ACK;
            end else begin
              nxt_r.wr_seen = 1'b1;
              if (r_ff.ptr == ACP_IDX_FIRST) begin
                nxt_r.ctrl1 = r_ff.sh;
              end else if (r_ff.ptr == ACP_IDX_SECOND) begin
                nxt_r.ctrl2 = r_ff.sh;
                nxt_r.wrote2 = 1'b1;
              end
              nxt_r.st = D_WACK;
            end
          end
        end
        D_ADDR_ACK: begin
          if (fall) begin
            if (r_ff.rw) begin
              nxt_r.sh = rd_byte;
              nxt_r.sda_oe = ~rd_byte[7];
              nxt_r.cnt = 4'h1;
              nxt_r.rd_idx = r_ff.rd_idx + 2'h1;
              nxt_r.st = D_RDATA;
            end else begin
              nxt_r.sda_oe = 1'b0;
              nxt_r.st = D_SUB;
            end
          end
        end
        D_SUB_ACK: begin
          if (fall) begin
            nxt_r.sda_oe = 1'b0;
            nxt_r.st = D_WDATA;
          end
        end
        D_WACK: begin
          if (fall) begin
            nxt_r.sda_oe = 1'b0;
            nxt_r.st = D_WDATA;
            if (r_ff.auto_inc) begin
              nxt_r.ptr = r_ff.ptr + 7'h01;
            end
          end
        end
        D_RDATA: begin
          if (fall) begin
            if (r_ff.cnt == ACP_BYTE_BITS) begin
              nxt_r.sda_oe = 1'b0;
              nxt_r.cnt = '0;
              nxt_r.st = D_RACK;
              if (r_ff.rd_idx == 2'h0) begin
                nxt_r.offset_run = 1'b0;
              end
            end else begin
              nxt_r.sh = {r_ff.sh[6:0], 1'b0};
              nxt_r.sda_oe = ~r_ff.sh[6];
              nxt_r.cnt = r_ff.cnt + 4'h1;
            end
          end
        end
        D_RACK: begin
          if (rise) begin
            nxt_r.nack = r_ff.sda_s;
          end else if (fall) begin
            if (r_ff.nack) begin
              nxt_r.st = D_IGNORE;
            end else begin
              nxt_r.sh = rd_byte;
              nxt_r.sda_oe = ~rd_byte[7];
              nxt_r.cnt = 4'h1;
              nxt_r.rd_idx = r_ff.rd_idx + 2'h1;
              nxt_r.st = D_RDATA;
            end
          end
        end
      endcase
    end
  end

  // state register, frozen while the enable is low
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      r_ff <= '0;
    end else if (CE_IN) begin
      r_ff <= nxt_r;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign I2C.d_sda_o = 1'b0;
  assign I2C.d_sda_oe = r_ff.sda_oe;
  assign CTRL_FIRST_OUT = r_ff.ctrl1;
  assign CTRL_SECOND_OUT = r_ff.ctrl2;
  assign AMP_ON_OUT = r_ff.ctrl2[ACP_STBY_BIT];
  assign DIAG_EN_OUT = r_ff.ctrl1[ACP_DIAG_EN_BIT];
  assign MUTE_OUT = r_ff.mute;
  assign GAIN_26DB_OUT = r_ff.gain26;
  assign OFFSET_RUN_OUT = r_ff.offset_run;
  assign DIAG_REQ_OUT = r_ff.diag_req;
  assign BUS_HOLD_OUT = r_ff.sda_oe;

endmodule

// [src/acp_host.sv]
// host end: bus controller issuing control writes and diagnostic reads
`timescale 1ns/1ns
module acp_host
  import acp_pkg::*;
(
  // clock, reset, enable
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic CE_IN,
  // link
  acp_i2c_if.host I2C,
  // command port
  input wire logic CMD_VALID_IN,
  input wire logic CMD_WRITE_IN,
  input wire logic [7:0] CMD_SUB_IN,
  input wire logic [7:0] CMD_FIRST_IN,
  input wire logic [7:0] CMD_SECOND_IN,
  output logic CMD_READY_OUT,
  // results
  output logic DONE_OUT,
  output logic NACK_ERR_OUT,
  output logic [31:0] RD_DATA_OUT
);

  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_GAP} acp_host_st_t;

  typedef struct packed {
    logic sda_m;
    logic sda_s;
    logic scl_oe;
    logic sda_oe;
    acp_host_st_t st;
    logic [7:0] q_cnt;
    logic [1:0] phase;
    logic [3:0] bit_cnt;
    logic [2:0] idx;
    logic is_rd;
    logic [8:0] tx;
    logic [8:0] rx;
    logic [7:0] sub;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [31:0] rdata;
    logic ready;
    logic done;
    logic nack_err;
  } acp_host_reg_t;

  acp_host_reg_t r_ff;
  acp_host_reg_t nxt_r;
  logic tick;
  logic [2:0] last_idx;

  // byte and acknowledge bit sent in each slot of a transfer
  function automatic logic [8:0] host_byte(input logic [2:0] idx, input logic rd,
                                           input logic [7:0] sub, input logic [7:0] d1,
                                           input logic [7:0] d2);
    logic [8:0] b;
    b = {ACP_IDLE_BYTE, 1'b0};
    if (idx == 3'h0) begin
      b = {ACP_DEV_ADDR, rd, 1'b1};
    end else if (rd) begin
      b = {ACP_IDLE_BYTE, idx == ACP_RD_LAST};
    end else if (idx == 3'h1) begin
      b = {sub, 1'b1};
    end else if (idx == 3'h2) begin
      b = {d1, 1'b1};
    end else begin
      b = {d2, 1'b1};
    end
    host_byte = b;
  endfunction

  assign tick = (r_ff.q_cnt == ACP_QUARTER_CYC - 8'h01);
  assign last_idx = r_ff.is_rd ? ACP_RD_LAST : ACP_WR_LAST;

  // ****************************************
  // bit sequencer, one quarter of a bus clock per phase
  // ****************************************
  always_comb begin
    nxt_r = r_ff;
    nxt_r.done = 1'b0;
    nxt_r.sda_m = I2C.sda;
    nxt_r.sda_s = r_ff.sda_m;
    if (r_ff.st == H_IDLE) begin
      nxt_r.q_cnt = '0;
      nxt_r.phase = '0;
      if (CMD_VALID_IN) begin
        nxt_r.is_rd = ~CMD_WRITE_IN;
        nxt_r.sub = CMD_SUB_IN;
        nxt_r.d1 = CMD_FIRST_IN;
        nxt_r.d2 = CMD_SECOND_IN;
        nxt_r.idx = '0;
        nxt_r.nack_err = 1'b0;
        nxt_r.st = H_START;
      end
    end else begin
      nxt_r.q_cnt = tick ? 8'h00 : r_ff.q_cnt + 8'h01;
      if (tick) begin
        nxt_r.phase = r_ff.phase + 2'h1;
        unique case (r_ff.st)
          H_START: begin
            if (r_ff.phase == 2'h1) begin
              nxt_r.sda_oe = 1'b1;
            end else if (r_ff.phase == 2'h2) begin
              nxt_r.scl_oe = 1'b1;
            end else if (r_ff.phase == 2'h3) begin
              nxt_r.tx = host_byte(3'h0, r_ff.is_rd, r_ff.sub, r_ff.d1, r_ff.d2);
              nxt_r.bit_cnt = '0;
              nxt_r.st = H_BIT;
            end
          end
          H_BIT: begin
            if (r_ff.phase == 2'h0) begin
              nxt_r.sda_oe = ~r_ff.tx[8];
            end else if (r_ff.phase == 2'h1) begin
              nxt_r.scl_oe = 1'b0;
            end else if (r_ff.phase == 2'h2) begin
              nxt_r.rx = {r_ff.rx[7:0], r_ff.sda_s};
            end else begin
              nxt_r.scl_oe = 1'b1;
              nxt_r.tx = {r_ff.tx[7:0], 1'b1};
              nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
              if (r_ff.bit_cnt == ACP_BYTE_BITS) begin
                if (r_ff.is_rd && (r_ff.idx != 3'h0)) begin
                  nxt_r.rdata = {r_ff.rx[8:1], r_ff.rdata[31:8]};
                end
                if ((!r_ff.is_rd || (r_ff.idx == 3'h0)) && r_ff.rx[0]) begin
                  nxt_r.nack_err = 1'b1;
                  nxt_r.st = H_STOP;
                end else if (r_ff.idx == last_idx) begin
                  nxt_r.st = H_STOP;
                end else begin
                  nxt_r.idx = r_ff.idx + 3'h1;
                  nxt_r.tx = host_byte(r_ff.idx + 3'h1, r_ff.is_rd, r_ff.sub, r_ff.d1,
                                       r_ff.d2);
                  nxt_r.bit_cnt = '0;
                end
              end
            end
          end
          H_STOP: begin
            if (r_ff.phase == 2'h0) begin
              nxt_r.sda_oe = 1'b1;
            end else if (r_ff.phase == 2'h1) begin
              nxt_r.scl_oe = 1'b0;
            end else if (r_ff.phase == 2'h2) begin
              nxt_r.sda_oe = 1'b0;
            end else begin
              nxt_r.bit_cnt = '0;
              nxt_r.st = H_GAP;
            end
          end
          H_GAP: begin
            // idle time before the next start
            nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
            if (r_ff.bit_cnt == ACP_GAP_QUARTERS - 4'h1) begin
              nxt_r.done = 1'b1;
              nxt_r.st = H_IDLE;
            end
          end
          default: begin
            nxt_r.st = H_IDLE;
          end
        endcase
      end
    end
    nxt_r.ready = (nxt_r.st == H_IDLE);
  end

  // state register, frozen while the enable is low
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      r_ff <= '0;
    end else if (CE_IN) begin
      r_ff <= nxt_r;
    end
  end

  // outputs
  assign I2C.h_scl_o = 1'b0;
  assign I2C.h_scl_oe = r_ff.scl_oe;
  assign I2C.h_sda_o = 1'b0;
  assign I2C.h_sda_oe = r_ff.sda_oe;
  assign CMD_READY_OUT = r_ff.ready;
  assign DONE_OUT = r_ff.done;
  assign NACK_ERR_OUT = r_ff.nack_err;
  assign RD_DATA_OUT = r_ff.rdata;

endmodule

// [testbench/acp_link_checker.sv]
// wire-level checks on the two-wire link between the host and device ends
`timescale 1ns/1ns
module acp_link_checker
  import acp_pkg::*;
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  // link signals
  input wire logic h_scl_o,
  input wire logic h_scl_oe,
  input wire logic h_sda_oe,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // ************
  // helper logic
  // ************
  localparam int PERIOD_CYC = ACP_SCL_PERIOD_NS / ACP_CLK_NS;
  logic prev_scl_ff, prev_sda_ff, start_w, stop_w, fall_w;
  logic [15:0] hi_cnt_ff;
  logic [15:0] idle_cnt_ff;
  logic [7:0] nfall_ff;

  // bus events seen on the resolved levels
  assign start_w = prev_scl_ff & scl & prev_sda_ff & ~sda;
  assign stop_w = prev_scl_ff & scl & ~prev_sda_ff & sda;
  assign fall_w = prev_scl_ff & ~scl;

  // clock high time, time since stop, clock falls since start
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      prev_scl_ff <= 1'b1;
      prev_sda_ff <= 1'b1;
      hi_cnt_ff <= 16'h0000;
      idle_cnt_ff <= 16'hffff;
      nfall_ff <= 8'h00;
    end else begin
      prev_scl_ff <= scl;
      prev_sda_ff <= sda;
      if (!scl) begin
        hi_cnt_ff <= 16'h0000;
      end else if (hi_cnt_ff != 16'hffff) begin
        hi_cnt_ff <= hi_cnt_ff + 16'h0001;
      end
      if (stop_w) begin
        idle_cnt_ff <= 16'h0000;
      end else if (idle_cnt_ff != 16'hffff) begin
        idle_cnt_ff <= idle_cnt_ff + 16'h0001;
      end
      if (start_w) begin
        nfall_ff <= 8'h00;
      end else if (fall_w && nfall_ff != 8'hff) begin
        nfall_ff <= nfall_ff + 8'h01;
      end
    end
  end

  // ************
  // assertions
  // ************
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);

  sequence start_seq;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence addr_end_seq;
    $fell(scl) && nfall_ff == 8'h08;
  endsequence

  scl_drain_a: assert property (h_scl_oe |-> !h_scl_o)
    else $error("host drives the clock line high");
  host_frame_a: assert property (scl && $changed(h_sda_oe) |-> $changed(sda))
    else $error("host data change under high clock is no start or stop");
  addr_ack_a: assert property (addr_end_seq |-> ##[1:6] d_sda_oe)
    else $error("device gave no acknowledge after the address byte");
  dev_edge_a: assert property ($changed(d_sda_oe) |-> !scl)
    else $error("device changed data while the clock was high");
  read_after_ack_a: assert property ($rose(d_sda_oe) |-> nfall_ff >= 8'h09)
    else $error("device drove data before the address acknowledge");
  scl_high_a: assert property ($fell(scl) |-> hi_cnt_ff >= {8'h00, ACP_QUARTER_CYC})
    else $error("clock high time too short");
  start_gap_a: assert property (start_seq |-> idle_cnt_ff >= 16'(PERIOD_CYC))
    else $error("new start without one idle clock period");
  idle_release_a: assert property (hi_cnt_ff >= 16'(PERIOD_CYC) |-> !d_sda_oe)
    else $error("device holds data line on an idle bus");
endmodule

// [testbench/amp_i2c_control_diag_port_bench.sv]
// self-checking bench joining the host and device ends over the link
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module amp_i2c_control_diag_port_bench
  import acp_pkg::*;
;
  // ************
  // signals and instances
  // ************
  logic clk, arst_n, cmd_valid, cmd_write, cmd_ready, done, nack_err;
  logic [7:0] cmd_sub, cmd_first, cmd_second, ctrl_first, ctrl_second;
  logic [23:0] chan_status;
  logic [3:0] offset_flag;
  logic [31:0] rd_data;
  logic amp_on, diag_en, mute, gain_26db, offset_run, diag_req, bus_hold;
  int n_errors = 0;
  int checks = 0;
  int n_req = 0;

  acp_i2c_if acp_i2c_if_inst();
  acp_host acp_host_inst (.CLK_IN(clk), .ARST_N_IN(arst_n), .CE_IN(1'b1),
    .I2C(acp_i2c_if_inst), .CMD_VALID_IN(cmd_valid), .CMD_WRITE_IN(cmd_write),
    .CMD_SUB_IN(cmd_sub), .CMD_FIRST_IN(cmd_first), .CMD_SECOND_IN(cmd_second),
    .CMD_READY_OUT(cmd_ready), .DONE_OUT(done), .NACK_ERR_OUT(nack_err),
    .RD_DATA_OUT(rd_data));
  acp_dev acp_dev_inst (.CLK_IN(clk), .ARST_N_IN(arst_n), .CE_IN(1'b1),
    .I2C(acp_i2c_if_inst), .CHAN_STATUS_IN(chan_status), .OFFSET_FLAG_IN(offset_flag),
    .CTRL_FIRST_OUT(ctrl_first), .CTRL_SECOND_OUT(ctrl_second), .AMP_ON_OUT(amp_on),
    .DIAG_EN_OUT(diag_en), .MUTE_OUT(mute), .GAIN_26DB_OUT(gain_26db),
    .OFFSET_RUN_OUT(offset_run), .DIAG_REQ_OUT(diag_req), .BUS_HOLD_OUT(bus_hold));
  acp_link_checker acp_link_checker_inst (.CLK_IN(clk), .ARST_N_IN(arst_n),
    .h_scl_o(acp_i2c_if_inst.h_scl_o), .h_scl_oe(acp_i2c_if_inst.h_scl_oe),
    .h_sda_oe(acp_i2c_if_inst.h_sda_oe), .d_sda_oe(acp_i2c_if_inst.d_sda_oe),
    .scl(acp_i2c_if_inst.scl), .sda(acp_i2c_if_inst.sda));

  // clock of 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // count diagnostic request pulses, sampled mid-cycle away from the launching edge
  always @(negedge clk) begin
    if (diag_req === 1'b1) n_req++;
  end

  // ************
  // tasks
  // ************
  task automatic complete_run();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one command through the host end, bounded waits
  task automatic cmd(input logic w, input logic [7:0] s, input logic [7:0] a,
                     input logic [7:0] b);
    int i;
    for (i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(negedge clk);
    `CHK(cmd_ready, 1'b1)
    if (cmd_ready !== 1'b1) complete_run();
    cmd_write = w;
    cmd_sub = s;
    cmd_first = a;
    cmd_second = b;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    for (i = 0; i < 6000 && done !== 1'b1; i++) @(negedge clk);
    `CHK(done, 1'b1)
    if (done !== 1'b1) complete_run();
    `CHK(nack_err, 1'b0)
    `CHK(bus_hold, 1'b0)
  endtask

  // expected four diagnostic bytes, channel one lowest
  function automatic logic [31:0] diag_exp(input logic stby, input logic den);
    logic [31:0] r;
    for (int k = 0; k < 4; k++) begin
      r[8*k +: 8] = {stby, den, chan_status[6*k +: 6]};
    end
    r[31:30] = 2'b00;
    return r;
  endfunction

  task automatic test_turn_on();
    int r0;
    r0 = n_req;
    cmd(1'b1, 8'h81, 8'ha1, 8'hf3);
    `CHK(ctrl_first, 8'ha1)
    `CHK(ctrl_second, 8'hf3)
    `CHK({amp_on, gain_26db, mute, diag_en}, 4'b1110)
    `CHK(n_req - r0, 0)
    $display("test_turn_on done");
  endtask

  task automatic test_diag();
    int r0;
    r0 = n_req;
    cmd(1'b1, 8'h81, 8'h40, 8'h10);
    `CHK(diag_en, 1'b1)
    `CHK(n_req - r0, 1)
    cmd(1'b0, 8'h00, 8'h00, 8'h00);
    `CHK(rd_data, diag_exp(1'b1, 1'b1))
    $display("test_diag done");
  endtask

  task automatic test_offset();
    cmd(1'b1, 8'h81, 8'h26, 8'h10);
    `CHK(offset_run, 1'b1)
    offset_flag = 4'ha;
    chan_status = 24'h104104;
    cmd(1'b0, 8'h00, 8'h00, 8'h00);
    `CHK(rd_data & 32'h04040404, 32'h04000400)
    `CHK(offset_run, 1'b0)
    offset_flag = 4'h0;
    chan_status = 24'h5a3c69;
    $display("test_offset done");
  endtask

  task automatic test_direct();
    cmd(1'b1, 8'h02, 8'h3c, 8'h14);
    `CHK(ctrl_second, 8'h14)
    `CHK(ctrl_first, 8'h26)
    $display("test_direct done");
  endtask

  // turn-off mutes, ends offset run, standby echo
  task automatic test_turn_off();
    cmd(1'b1, 8'h81, 8'h26, 8'h10);
    `CHK(offset_run, 1'b1)
    cmd(1'b1, 8'h81, 8'h26, 8'h00);
    `CHK({amp_on, gain_26db, mute, offset_run}, 4'b0010)
    cmd(1'b0, 8'h00, 8'h00, 8'h00);
    `CHK(rd_data, diag_exp(1'b0, 1'b0))
    $display("test_turn_off done");
  endtask

  // ************
  // main sequence
  // ************
  initial begin
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_sub = 8'h00;
    cmd_first = 8'h00;
    cmd_second = 8'h00;
    chan_status = 24'h5a3c69;
    offset_flag = 4'h0;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    test_turn_off();
    test_turn_on();
    test_diag();
    test_offset();
    test_direct();
    complete_run();
  end
endmodule
